// *** rtl/ccp_clock_ctrl.sv ***
// clock controller top: register slave, clock enables, loop control
// Contract
// - three clock outputs: core, peripheral, USB
// - peripheral clock is base of peripheral ticks
// - each clock gated by power reduction mode
// - oscillator pin also accepts external 48 MHz
// - oscillator inverter on unless bypass bit set
// - detector compares reference and feedback, pulses
// - loop output drives USB, locked to peripheral
// - loop runs only with enable bit set
// - hardware sets lock flag on lock
// - divider register holds typical ratio-minus-one settings
// - rate selects ignored unless double speed set
// - rate select: clear six, set twelve periods
// - bypass bit two: skip loop, oscillator off
// - loop enable is control bit one
// - lock flag bit zero, cleared on unlock
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ccp_clock_ctrl #(
  parameter int LOCK_CNT = ccp_pkg::LOCK_COMPARES
) (
  input  wire logic                       aclk,            // 25 MHz clock
  input  wire logic                       aresetn,         // sync reset, low
  input  wire logic [ccp_pkg::ADDR_W-1:0] awaddr,          // write address
  input  wire logic                       awvalid,         // write address valid
  output logic                            awready,         // write address ready
  input  wire logic [31:0]                wdata,           // write data
  input  wire logic [3:0]                 wstrb,           // write byte lanes
  input  wire logic                       wvalid,          // write data valid
  output logic                            wready,          // write data ready
  output logic [1:0]                      bresp,           // write response
  output logic                            bvalid,          // write response valid
  input  wire logic                       bready,          // write response ready
  input  wire logic [ccp_pkg::ADDR_W-1:0] araddr,          // read address
  input  wire logic                       arvalid,         // read address valid
  output logic                            arready,         // read address ready
  output logic [31:0]                     rdata,           // read data
  output logic [1:0]                      rresp,           // read response
  output logic                            rvalid,          // read data valid
  input  wire logic                       rready,          // read data ready
  input  wire logic                       oscillator_input_pin, // crystal or 48 MHz source
  output logic                            osc_inverter_en, // oscillator inverter on
  output logic                            cpu_clk_en,      // core clock pulse
  output logic                            per_clk_en,      // peripheral clock pulse
  output logic                            usb_clk_en,      // USB clock pulse
  output logic [ccp_pkg::NUM_PERIPH-1:0]  periph_tick,     // per-peripheral clock pulses
  output logic                            loop_up,         // detector speed-up pulse
  output logic                            loop_down        // detector slow-down pulse
);
  // ==========================================================
  // registers
  logic [7:0] rate_ff;
  logic [7:0] div_ff;
  logic       loop_en_ff, bypass_ff;
  logic [1:0] pwr_ff;
  logic       pin_prev_ff, half_ff;
  logic       aw_hold_ff, w_hold_ff;
  logic [ccp_pkg::ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        vco_tick, loop_lock;
  logic        up_raw, down_raw;

  // ==========================================================
  // write channel
  wire aw_take  = awvalid & awready;
  wire w_take   = wvalid & wready;
  wire aw_full  = aw_hold_ff | aw_take;
  wire w_full   = w_hold_ff | w_take;
  wire do_write = aw_full & w_full;
  wire nxt_aw_hold = aw_full & ~do_write;
  wire nxt_w_hold  = w_full & ~do_write;
  wire nxt_bvalid  = do_write | (bvalid & ~bready);
  wire [ccp_pkg::ADDR_W-1:0] wa  = aw_hold_ff ? awaddr_ff : awaddr;
  wire [31:0]                wd  = w_hold_ff ? wdata_ff : wdata;
  wire [3:0]                 ws  = w_hold_ff ? wstrb_ff : wstrb;
  wire [9:0]                 widx = wa[ccp_pkg::ADDR_W-1:2];
  wire wr_lane  = do_write & ws[0];
  wire w_rate   = (widx == ccp_pkg::IDX_RATE);
  wire w_loop   = (widx == ccp_pkg::IDX_LOOP);
  wire w_div    = (widx == ccp_pkg::IDX_DIV);
  wire w_pwr    = (widx == ccp_pkg::IDX_PWR);
  wire w_hit    = w_rate | w_loop | w_div | w_pwr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= ccp_pkg::RESP_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      if (aw_take) awaddr_ff <= awaddr;
      if (w_take) wdata_ff <= wdata;
      if (w_take) wstrb_ff <= wstrb;
      awready    <= ~nxt_aw_hold & ~nxt_bvalid;
      wready     <= ~nxt_w_hold & ~nxt_bvalid;
      bvalid     <= nxt_bvalid;
      if (do_write) bresp <= w_hit ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
    end
  end

  // ==========================================================
  // control registers; lock flag is hardware-owned, writes ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rate_ff    <= ccp_pkg::RATE_RST;
      div_ff     <= ccp_pkg::DIV_RST;
      loop_en_ff <= 1'b0;
      bypass_ff  <= 1'b0;
      pwr_ff     <= ccp_pkg::PWR_RST;
    end else begin
      if (wr_lane && w_rate) rate_ff <= wd[7:0];
      if (wr_lane && w_div) div_ff <= wd[7:0];
      if (wr_lane && w_loop) begin
        loop_en_ff <= wd[ccp_pkg::LOOP_EN_BIT];
        bypass_ff  <= wd[ccp_pkg::BYPASS_BIT];
      end
      if (wr_lane && w_pwr) pwr_ff <= wd[1:0];
    end
  end

  // ==========================================================
  // read channel
  wire ar_take    = arvalid & arready;
  wire nxt_rvalid = ar_take | (rvalid & ~rready);
  wire [9:0] ridx = araddr[ccp_pkg::ADDR_W-1:2];
  wire r_rate = (ridx == ccp_pkg::IDX_RATE);
  wire r_loop = (ridx == ccp_pkg::IDX_LOOP);
  wire r_div  = (ridx == ccp_pkg::IDX_DIV);
  wire r_pwr  = (ridx == ccp_pkg::IDX_PWR);
  wire r_hit  = r_rate | r_loop | r_div | r_pwr;
  wire [7:0] loop_rd = {5'h00, bypass_ff, loop_en_ff, loop_lock};
  wire [7:0] rd_byte = r_rate ? rate_ff :
                       r_loop ? loop_rd :
                       r_div  ? div_ff  :
                       r_pwr  ? {6'h00, pwr_ff} : 8'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= ccp_pkg::RESP_OKAY;
    end else begin
      arready <= ~nxt_rvalid;
      rvalid  <= nxt_rvalid;
      if (ar_take) begin
        rdata <= {24'h000000, rd_byte};
        rresp <= r_hit ? ccp_pkg::RESP_OKAY : ccp_pkg::RESP_SLVERR;
      end
    end
  end

  // ==========================================================
  // source and rate division
  // the pin is one source for crystal and external clock alike;
  // each rising edge is one oscillator period
  wire osc_tick = oscillator_input_pin & ~pin_prev_ff;
  wire x2       = rate_ff[ccp_pkg::CORE_X2_BIT];
  wire slow_tick = osc_tick & half_ff;
  wire per_raw  = x2 ? osc_tick : slow_tick;
  wire idle     = pwr_ff[ccp_pkg::IDLE_BIT];
  wire pdown    = pwr_ff[ccp_pkg::PDOWN_BIT];
  // external source skips the loop entirely
  wire usb_raw  = bypass_ff ? osc_tick : (vco_tick & loop_en_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_ff     <= 1'b0;
      half_ff         <= 1'b0;
      osc_inverter_en <= 1'b0;
      cpu_clk_en      <= 1'b0;
      per_clk_en      <= 1'b0;
      usb_clk_en      <= 1'b0;
      loop_up         <= 1'b0;
      loop_down       <= 1'b0;
    end else begin
      pin_prev_ff     <= oscillator_input_pin;
      if (osc_tick) half_ff <= ~half_ff;
      osc_inverter_en <= ~bypass_ff;
      cpu_clk_en      <= per_raw & ~idle & ~pdown;
      per_clk_en      <= per_raw & ~pdown;
      usb_clk_en      <= usb_raw & ~pdown;
      loop_up         <= up_raw;
      loop_down       <= down_raw;
    end
  end

  // ==========================================================
  // per-peripheral rates, one per rate-select bit above the core bit
  genvar gi;
  generate
    for (gi = 0; gi < ccp_pkg::NUM_PERIPH; gi++) begin : g_periph
      // a select bit only counts while the core runs double speed
      wire fast = x2 & ~rate_ff[gi + 1];
      wire raw  = fast ? osc_tick : slow_tick;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          periph_tick[gi] <= 1'b0;
        end else begin
          periph_tick[gi] <= raw & ~pdown;
        end
      end
    end
  endgenerate

  // ==========================================================
  // loop, referenced to the ungated peripheral clock
  ccp_loop_model #(
    .LOCK_CNT (LOCK_CNT)
  ) u_loop (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .enable   (loop_en_ff & ~bypass_ff),
    .ref_tick (per_raw),
    .n_div    (div_ff[ccp_pkg::DIV_N_LSB +: ccp_pkg::DIV_FLD_W]),
    .r_div    (div_ff[ccp_pkg::DIV_R_LSB +: ccp_pkg::DIV_FLD_W]),
    .vco_tick (vco_tick),
    .up       (up_raw),
    .down     (down_raw),
    .locked   (loop_lock)
  );

  // ==========================================================
  // checks
  property p_inv_off;
    @(posedge aclk) disable iff (!aresetn) bypass_ff [*2] |-> !osc_inverter_en;
  endproperty
  a_inv_off: assert property (p_inv_off) else $error("inverter on while bypassed");

  property p_inv_on;
    @(posedge aclk) disable iff (!aresetn) !bypass_ff [*2] |-> osc_inverter_en;
  endproperty
  a_inv_on: assert property (p_inv_on) else $error("inverter off while loop selected");

  property p_pdown_gate;
    @(posedge aclk) disable iff (!aresetn) pdown |=> !cpu_clk_en && !per_clk_en && !usb_clk_en;
  endproperty
  a_pdown_gate: assert property (p_pdown_gate) else $error("clock pulse in power-down");

  property p_idle_gate;
    @(posedge aclk) disable iff (!aresetn) idle && !pdown && per_raw |=> !cpu_clk_en && per_clk_en;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("idle gating wrong");

  property p_rate_ignored;
    @(posedge aclk) disable iff (!aresetn) !x2 && osc_tick && !half_ff |=> periph_tick == '0;
  endproperty
  a_rate_ignored: assert property (p_rate_ignored) else $error("rate bit acted without x2");

  property p_rate_six;
    @(posedge aclk) disable iff (!aresetn)
      x2 && !rate_ff[ccp_pkg::NUM_PERIPH] && osc_tick && !pdown |=> periph_tick[ccp_pkg::NUM_PERIPH-1];
  endproperty
  a_rate_six: assert property (p_rate_six) else $error("six-period rate missing");

  property p_en_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_lane && w_loop |=> loop_en_ff == $past(wd[ccp_pkg::LOOP_EN_BIT]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable bit not stored");

  property p_usb_bypass;
    @(posedge aclk) disable iff (!aresetn) bypass_ff && osc_tick && !pdown |=> usb_clk_en;
  endproperty
  a_usb_bypass: assert property (p_usb_bypass) else $error("bypass source not on USB clock");
endmodule

// *** rtl/ccp_pkg.sv ***
// shared constants and types for the clock and loop controller
package ccp_pkg;
  // ==========================================================
  // register map (indices; byte address = index * 4)
  localparam int          ADDR_W    = 12;
  localparam logic [9:0]  IDX_RATE  = 10'h08F;
  localparam logic [9:0]  IDX_LOOP  = 10'h0A3;
  localparam logic [9:0]  IDX_DIV   = 10'h0A4;
  localparam logic [9:0]  IDX_PWR   = 10'h0B0;
  // ==========================================================
  // reset values and field positions
  localparam logic [7:0]  RATE_RST  = 8'h00;
  localparam logic [7:0]  DIV_RST   = 8'h00;
  localparam logic [1:0]  PWR_RST   = 2'h0;
  localparam int          CORE_X2_BIT = 0;
  localparam int          LOCK_BIT    = 0;
  localparam int          LOOP_EN_BIT = 1;
  localparam int          BYPASS_BIT  = 2;
  localparam int          IDLE_BIT    = 0;
  localparam int          PDOWN_BIT   = 1;
  localparam int          DIV_N_LSB   = 0;
  localparam int          DIV_R_LSB   = 4;
  localparam int          DIV_FLD_W   = 4;
  localparam int          NUM_PERIPH  = 7;
  // ==========================================================
  // bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ==========================================================
  // loop model
  localparam int          EXT_CLK_MHZ   = 48;
  localparam int          LOCK_COMPARES = 8;
  localparam int          DCO_W         = 8;
  localparam logic [7:0]  DCO_INIT      = 8'h10;
  typedef enum logic [1:0] {
    CCP_LOOP_OFF  = 2'b00,
    CCP_LOOP_ACQ  = 2'b01,
    CCP_LOOP_LOCK = 2'b11
  } ccp_loop_state_t;
endpackage

// *** rtl/ccp_loop_model.sv ***
// digital model of the frequency loop: dividers, detector, oscillator
`timescale 1ns/1ps
module ccp_loop_model #(
  parameter int LOCK_CNT = ccp_pkg::LOCK_COMPARES
) (
  input  wire logic       aclk,      // system clock
  input  wire logic       aresetn,   // sync reset, low
  input  wire logic       enable,    // loop enable
  input  wire logic       ref_tick,  // peripheral clock reference
  input  wire logic [3:0] n_div,     // input divider minus one
  input  wire logic [3:0] r_div,     // feedback divider minus one
  output logic            vco_tick,  // loop output pulse
  output logic            up,        // detector speed-up pulse
  output logic            down,      // detector slow-down pulse
  output logic            locked     // lock indication
);
  // ==========================================================
  // state
  ccp_pkg::ccp_loop_state_t state_ff, nxt_state;
  logic [3:0]              ref_cnt_ff, fb_cnt_ff;
  logic [ccp_pkg::DCO_W-1:0] per_ff, dco_cnt_ff;
  logic [1:0]              fb_seen_ff;
  logic [3:0]              good_ff;
  // ==========================================================
  // dividers and compare
  wire ref_edge = enable & ref_tick & (ref_cnt_ff == n_div);
  wire fb_edge  = vco_tick & (fb_cnt_ff == r_div);
  wire [1:0] fb_total = (fb_seen_ff == 2'h2) ? 2'h2 : fb_seen_ff + {1'b0, fb_edge};
  wire too_slow = ref_edge & (fb_total == 2'h0);
  wire too_fast = ref_edge & (fb_total == 2'h2);
  wire good_cmp = ref_edge & (fb_total == 2'h1);
  wire good_full = (good_ff == 4'(LOCK_CNT - 1));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ccp_pkg::CCP_LOOP_OFF:  if (enable) nxt_state = ccp_pkg::CCP_LOOP_ACQ;
      ccp_pkg::CCP_LOOP_ACQ:  if (good_cmp && good_full) nxt_state = ccp_pkg::CCP_LOOP_LOCK;
      ccp_pkg::CCP_LOOP_LOCK: if (too_slow || too_fast) nxt_state = ccp_pkg::CCP_LOOP_ACQ;
      default:                nxt_state = ccp_pkg::CCP_LOOP_OFF;
    endcase
    if (!enable) nxt_state = ccp_pkg::CCP_LOOP_OFF;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      state_ff   <= ccp_pkg::CCP_LOOP_OFF;
      ref_cnt_ff <= 4'h0;
      fb_cnt_ff  <= 4'h0;
      dco_cnt_ff <= '0;
      per_ff     <= ccp_pkg::DCO_INIT;
      fb_seen_ff <= 2'h0;
      good_ff    <= 4'h0;
      vco_tick   <= 1'b0;
      up         <= 1'b0;
      down       <= 1'b0;
      locked     <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (ref_tick) ref_cnt_ff <= (ref_cnt_ff == n_div) ? 4'h0 : ref_cnt_ff + 4'h1;
      if (vco_tick) fb_cnt_ff <= (fb_cnt_ff == r_div) ? 4'h0 : fb_cnt_ff + 4'h1;
      // oscillator period steered by the detector; clamped so it never stalls
      dco_cnt_ff <= (dco_cnt_ff >= per_ff) ? '0 : dco_cnt_ff + 1'b1;
      vco_tick   <= (dco_cnt_ff >= per_ff);
      if (too_slow && per_ff != '0) per_ff <= per_ff - 1'b1;
      if (too_fast && per_ff != '1) per_ff <= per_ff + 1'b1;
      fb_seen_ff <= ref_edge ? 2'h0 : fb_total;
      up         <= too_slow;
      down       <= too_fast;
      if (too_slow || too_fast) good_ff <= 4'h0;
      else if (good_cmp && !good_full) good_ff <= good_ff + 4'h1;
      locked     <= (nxt_state == ccp_pkg::CCP_LOOP_LOCK);
    end
  end

  // ==========================================================
  // checks
  property p_off_silent;
    @(posedge aclk) disable iff (!aresetn) !enable |=> !vco_tick && !locked;
  endproperty
  a_off_silent: assert property (p_off_silent) else $error("loop active while disabled");

  property p_lose_lock;
    @(posedge aclk) disable iff (!aresetn) (too_slow || too_fast) |=> !locked;
  endproperty
  a_lose_lock: assert property (p_lose_lock) else $error("lock kept after bad compare");

  property p_gain_lock;
    @(posedge aclk) disable iff (!aresetn) $rose(locked) |-> $past(good_cmp) && $past(enable);
  endproperty
  a_gain_lock: assert property (p_gain_lock) else $error("lock set without good compare");

  property p_up_pulse;
    @(posedge aclk) disable iff (!aresetn) too_slow && enable |=> up ##1 (!up || $past(too_slow));
  endproperty
  a_up_pulse: assert property (p_up_pulse) else $error("speed-up pulse wrong");
endmodule

// *** testbench/ccp_osc_model.sv ***
// off-chip clock source model driving the oscillator input pin
`timescale 1ns/1ps
module ccp_osc_model #(
  parameter int HALF = 4
) (
  input  wire logic aclk, // bench clock
  input  wire logic run,  // source running
  output logic      pin   // oscillator pin level
);
  // ==========================================================
  // square wave, HALF aclk cycles high then low
  int cnt;
  initial begin
    pin = 1'b0;
    cnt = 0;
  end
  // stopped source sits low: no edges reach the controller
  always @(posedge aclk) begin
    if (!run) begin
      pin <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      pin <= ~pin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the clock and loop controller
`timescale 1ns/1ps
module tb;
  logic aclk = 0, aresetn = 0, run = 0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, pin, inv_en, cpu, per, usb, up, dn;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  logic [6:0] ptick;
  logic [1:0] rsp;
  int err_total = 0, check_count = 0, c_cpu, c_per, c_usb, c_p6, c_p0, seen_up, seen_dn;
  localparam logic [11:0] A_RATE = {ccp_pkg::IDX_RATE, 2'b00}, A_LOOP = {ccp_pkg::IDX_LOOP, 2'b00};
  localparam logic [11:0] A_DIV = {ccp_pkg::IDX_DIV, 2'b00}, A_PWR = {ccp_pkg::IDX_PWR, 2'b00};
  always #20 aclk = ~aclk;
  ccp_osc_model #(.HALF(4)) osc (.aclk(aclk), .run(run), .pin(pin));
  ccp_clock_ctrl #(.LOCK_CNT(2)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .oscillator_input_pin(pin),
    .osc_inverter_en(inv_en), .cpu_clk_en(cpu), .per_clk_en(per), .usb_clk_en(usb),
    .periph_tick(ptick), .loop_up(up), .loop_down(dn));
  always @(posedge aclk) if (up === 1'b1) seen_up <= seen_up + 1;
  always @(posedge aclk) if (dn === 1'b1) seen_dn <= seen_dn + 1;
  // ==========================================================
  // reporting
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic hang(string name);
    err_total++;
    $display("Error %s expected answer seen timeout", name);
    close_out();
  endtask
  // ==========================================================
  // bus master: hold each channel until its own ready
  // late data offered one edge after the address exercises the held-address path
  task automatic axi_wr(logic [11:0] a, logic [31:0] d, logic [1:0] er, bit late = 1'b0);
    int i;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= !late; bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (late && i == 0) wvalid <= 1'b1;
      if (bvalid === 1'b1) break;
    end
    if (i == 50) hang("write");
    bready <= 1'b0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (i == 50) hang("read");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rd_chk(string n, logic [11:0] a, logic [31:0] ed, logic [1:0] er);
    axi_rd(a, rd, rsp);
    check(n, rd, ed);
    check("rresp", {30'h0, rsp}, {30'h0, er});
  endtask
  // count pulses over 20 oscillator periods starting at a rising edge
  task automatic count_clk();
    int i;
    logic prev;
    prev = pin;
    for (i = 0; i < 100; i++) begin
      @(posedge aclk);
      if (!prev && pin) break;
      prev = pin;
    end
    if (i == 100) hang("osc edge");
    c_cpu = 0; c_per = 0; c_usb = 0; c_p6 = 0; c_p0 = 0;
    repeat (160) begin
      @(posedge aclk);
      c_cpu += int'(cpu === 1'b1); c_per += int'(per === 1'b1); c_usb += int'(usb === 1'b1);
      c_p6 += int'(ptick[6] === 1'b1); c_p0 += int'(ptick[0] === 1'b1);
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd_chk("rate rst", A_RATE, 32'h0, ccp_pkg::RESP_OKAY);
    rd_chk("loop rst", A_LOOP, 32'h0, ccp_pkg::RESP_OKAY);
    rd_chk("div rst", A_DIV, 32'h0, ccp_pkg::RESP_OKAY);
    rd_chk("pwr rst", A_PWR, 32'h0, ccp_pkg::RESP_OKAY);
    check("inverter on", {31'h0, inv_en}, 32'h1);
    axi_wr(12'hFFC, 32'h5A, ccp_pkg::RESP_SLVERR);
    rd_chk("unmapped", 12'hFFC, 32'h0, ccp_pkg::RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_regs();
    axi_wr(A_DIV, 32'hB9, ccp_pkg::RESP_OKAY);
    rd_chk("div B9", A_DIV, 32'hB9, ccp_pkg::RESP_OKAY);
    axi_wr(A_DIV, 32'hF0, ccp_pkg::RESP_OKAY);
    rd_chk("div F0", A_DIV, 32'hF0, ccp_pkg::RESP_OKAY);
    wstrb <= 4'hE;
    axi_wr(A_DIV, 32'h12, ccp_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd_chk("div strb", A_DIV, 32'hF0, ccp_pkg::RESP_OKAY);
    axi_wr(A_DIV, 32'h30, ccp_pkg::RESP_OKAY, 1'b1);
    rd_chk("div late w", A_DIV, 32'h30, ccp_pkg::RESP_OKAY);
    axi_wr(A_LOOP, 32'hFD, ccp_pkg::RESP_OKAY);
    rd_chk("loop ro", A_LOOP, 32'h4, ccp_pkg::RESP_OKAY);
    axi_wr(A_LOOP, 32'h0, ccp_pkg::RESP_OKAY);
    $display("test regs done");
  endtask
  task automatic t_rates();
    axi_wr(A_RATE, 32'h80, ccp_pkg::RESP_OKAY);
    count_clk();
    check("per x1", c_per, 10);
    check("cpu x1", c_cpu, 10);
    check("twi ignored", c_p6, 10);
    axi_wr(A_RATE, 32'h81, ccp_pkg::RESP_OKAY);
    count_clk();
    check("per x2", c_per, 20);
    check("twi twelve", c_p6, 10);
    check("timer0 six", c_p0, 20);
    $display("test rates done");
  endtask
  task automatic t_power();
    axi_wr(A_PWR, 32'h1, ccp_pkg::RESP_OKAY);
    count_clk();
    check("idle cpu", c_cpu, 0);
    check("idle per", c_per, 20);
    check("idle timer0", c_p0, 20);
    axi_wr(A_PWR, 32'h2, ccp_pkg::RESP_OKAY);
    // bypass gives the USB clock a live source, so the gate is really tested
    axi_wr(A_LOOP, 32'h4, ccp_pkg::RESP_OKAY);
    count_clk();
    check("pdown per", c_per, 0);
    check("pdown usb", c_usb, 0);
    check("pdown cpu", c_cpu, 0);
    check("pdown timer0", c_p0, 0);
    axi_wr(A_LOOP, 32'h0, ccp_pkg::RESP_OKAY);
    axi_wr(A_PWR, 32'h0, ccp_pkg::RESP_OKAY);
    $display("test power done");
  endtask
  task automatic t_bypass();
    axi_wr(A_LOOP, 32'h4, ccp_pkg::RESP_OKAY);
    count_clk();
    check("bypass usb", c_usb, 20);
    check("inverter off", {31'h0, inv_en}, 32'h0);
    axi_wr(A_LOOP, 32'h0, ccp_pkg::RESP_OKAY);
    count_clk();
    check("inverter back", {31'h0, inv_en}, 32'h1);
    check("loop off usb", c_usb, 0);
    $display("test bypass done");
  endtask
  task automatic t_lock();
    int i, b_up, b_dn;
    b_up = seen_up;
    b_dn = seen_dn;
    axi_wr(A_DIV, 32'h10, ccp_pkg::RESP_OKAY);
    axi_wr(A_LOOP, 32'h2, ccp_pkg::RESP_OKAY);
    for (i = 0; i < 300; i++) begin
      axi_rd(A_LOOP, rd, rsp);
      if (rd[0] === 1'b1) break;
    end
    if (i == 300) hang("lock");
    check("lock set", rd, 32'h3);
    check("up seen", int'(seen_up > b_up), 1);
    count_clk();
    check("usb from loop", int'(c_usb > 0), 1);
    // feedback ratio one makes the loop run too fast against the reference
    axi_wr(A_DIV, 32'h00, ccp_pkg::RESP_OKAY);
    repeat (40) @(posedge aclk);
    check("down seen", int'(seen_dn > b_dn), 1);
    axi_wr(A_LOOP, 32'h0, ccp_pkg::RESP_OKAY);
    rd_chk("lock clear", A_LOOP, 32'h0, ccp_pkg::RESP_OKAY);
    $display("test lock done");
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_regs();
    t_rates();
    t_power();
    t_bypass();
    t_lock();
    close_out();
  end
endmodule
